// >>> mgmt_pkg.sv
package mgmt_pkg;

  // clock and timing
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_INIT_MS = 2000;
  localparam int INIT_CYC = T_INIT_MS * (CLK_HZ / 1000);
  localparam int T_RESET_MIN_US = 2;
  localparam int RESET_MIN_CYC = (T_RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // bus address (8-bit form A0h)
  localparam logic [6:0] DEV_ADDR = 7'h50;

  // memory layout
  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam int DNR_BIT = 0;
  localparam logic [7:0] OFS_LOCK_FLAGS = 8'h05;
  localparam logic [7:0] OFS_POWER_CTRL = 8'h5D;
  localparam int PDOWN_BIT = 0;
  localparam logic [7:0] OFS_RETIMER_EN = 8'h62;
  localparam logic [7:0] OFS_LOCK_MASK = 8'h66;
  localparam logic [7:0] OFS_PAGE_SEL = 8'h7F;
  localparam logic [7:0] LOWER_RW_FIRST = 8'h56;
  localparam logic [7:0] UPPER_RW_FIRST = 8'hE2;
  localparam logic [7:0] MEM_RST = 8'h00;

  // link engine states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ACK_ADDR = 4'h2,
    ST_OFFS = 4'h3,
    ST_ACK_OFFS = 4'h4,
    ST_WDATA = 4'h5,
    ST_ACK_W = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK = 4'h8
  } link_state_t;

  // per-lane flag byte: tx lanes 4..1 high nibble, rx lanes 4..1 low nibble
  typedef struct packed {
    logic [3:0] tx;
    logic [3:0] rx;
  } lane_pair_t;

  // snapshot of a byte read from a clear-on-read location
  typedef struct packed {
    logic is_status;
    logic [7:0] bits;
  } read_clear_t;

endpackage

// >>> module_mgmt_control_logic.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: answer bus commands while select is low
// R2: ignore bus while select high; pull-up
// R3: long reset-pin low restores all defaults; memory bytes clear only if the bus clock runs while the pin is low
// R4: host ignores status until completion interrupt
// R5: completion shown by interrupt, not-ready negated
// R6: completion interrupt raised after power-up
// R7: low-power pin enters lower power quickly
// R8: presence output tied low
// R9: interrupt pin driven low on conditions
// R10: host reads flags to find source
// R11: 128-byte lower page plus selectable pages
// R12: memory answers at device address A0h
// R13: byte 5 holds latched lane lock-loss
// R14: byte 98 holds per-lane retimer enables
// R15: upper page read-only thresholds, writable controls
// R16: fully functional within init time
// R17: bus ready, not-ready negated within limit
// R18: flags and interrupt set within limits
// R19: read clears flag, interrupt then releases
// R20: mask changes reach interrupt within limit
// R21: select change takes effect within limit
// R22: power-down override bit lowers power
// R23: interrupt while any unmasked flag set
module module_mgmt_control_logic import mgmt_pkg::*; #(
  parameter int INIT_CYCLES = INIT_CYC,
  parameter int PAGES = 4
) (
  // system
  input wire logic CLK,
  input wire logic RST,
  // management bus
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  // control pins
  input wire logic MODULE_SELECT_N,
  input wire logic MODULE_RESET_N,
  input wire logic LOW_POWER_REQUEST,
  output logic MODULE_PRESENT_N,
  output logic INTERRUPT_N_O,
  output logic INTERRUPT_N_OE,
  // lanes and power
  input wire logic [3:0] TX_LOCK_LOST,
  input wire logic [3:0] RX_LOCK_LOST,
  output logic [3:0] TX_RETIMER_ENABLE,
  output logic [3:0] RX_RETIMER_ENABLE,
  output logic POWER_LOW
);

  localparam int PW = $clog2(PAGES + 1);
  localparam int IW = $clog2(INIT_CYCLES + 1);

  // clk domain state
  logic rstn_s1, rstn_s2, lp_s1, lp_s2, pd_s1, pd_s2;
  lane_pair_t lock_s1, lock_s;
  logic [7:0] mask_s1, mask_s, ret_s1, ret_s;
  logic clr_s1, clr_s2, clr_s3;
  logic [7:0] rst_low_cnt_reg;
  logic soft_rst_reg, link_rst_req_reg;
  logic [IW-1:0] init_cnt_reg;
  logic dnr_reg, done_reg, irq_oe_reg, power_low_reg;
  lane_pair_t flag_reg;
  logic clr_evt;
  logic [7:0] clr_lock;
  logic clr_done;

  // link domain state
  logic rst_scl_s1, rst_scl_reg, sel_n_s1, sel_n_s2, dnr_s1, dnr_scl;
  logic [7:0] flags_s1, flags_scl;
  logic sda_hi_reg, sda_oe_reg, rw_reg, clr_tog_reg;
  link_state_t state_reg;
  logic [2:0] cnt_reg;
  logic [7:0] sh_reg, tx_reg, offset_reg;
  read_clear_t clr_snap_reg;
  logic [7:0] mem_reg [0:PAGES][0:127];
  logic start_c, stop_c, link_go, byte_done, load_rd, wr_now, row_ok, writable;
  logic [7:0] byte_in, rd_value, page_sel;
  logic [PW-1:0] row_idx;

  // ---------------- clk domain ----------------

  always_ff @(posedge CLK) begin
    if (RST) begin
      rstn_s1 <= 1'b1;
      rstn_s2 <= 1'b1;
      lp_s1 <= 1'b0;
      lp_s2 <= 1'b0;
      pd_s1 <= 1'b0;
      pd_s2 <= 1'b0;
      lock_s1 <= '0;
      lock_s <= '0;
      mask_s1 <= MEM_RST;
      mask_s <= MEM_RST;
      ret_s1 <= MEM_RST;
      ret_s <= MEM_RST;
      clr_s1 <= 1'b0;
      clr_s2 <= 1'b0;
      clr_s3 <= 1'b0;
    end else begin
      rstn_s1 <= MODULE_RESET_N;
      rstn_s2 <= rstn_s1;
      lp_s1 <= LOW_POWER_REQUEST;
      lp_s2 <= lp_s1;
      pd_s1 <= mem_reg[0][OFS_POWER_CTRL[6:0]][PDOWN_BIT];
      pd_s2 <= pd_s1;
      lock_s1 <= lane_pair_t'({TX_LOCK_LOST, RX_LOCK_LOST});
      lock_s <= lock_s1;
      mask_s1 <= mem_reg[0][OFS_LOCK_MASK[6:0]];
      mask_s <= mask_s1;
      ret_s1 <= mem_reg[0][OFS_RETIMER_EN[6:0]];
      ret_s <= ret_s1;
      clr_s1 <= clr_tog_reg;
      clr_s2 <= clr_s1;
      clr_s3 <= clr_s2;
    end
  end

  // reset pin qualification
  always_ff @(posedge CLK) begin
    if (RST || rstn_s2) begin
      rst_low_cnt_reg <= 8'h00;
      soft_rst_reg <= 1'b0;
    end else if (rst_low_cnt_reg == 8'(RESET_MIN_CYC)) begin
      soft_rst_reg <= 1'b1; // R3
    end else begin
      rst_low_cnt_reg <= rst_low_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge CLK) begin
    link_rst_req_reg <= RST | soft_rst_reg; // R3
  end

  // initialisation timer and data-not-ready
  always_ff @(posedge CLK) begin
    if (RST || soft_rst_reg) begin
      init_cnt_reg <= '0;
      dnr_reg <= 1'b1;
    end else if (dnr_reg) begin
      if (init_cnt_reg == IW'(INIT_CYCLES - 1)) begin
        dnr_reg <= 1'b0; // R16 R17
      end else begin
        init_cnt_reg <= init_cnt_reg + 1'b1;
      end
    end
  end

  assign clr_evt = clr_s2 ^ clr_s3;
  assign clr_lock = (clr_evt && !clr_snap_reg.is_status) ? clr_snap_reg.bits : 8'h00;
  assign clr_done = clr_evt && clr_snap_reg.is_status && !clr_snap_reg.bits[DNR_BIT];

  // completion flag, set wins over clear
  always_ff @(posedge CLK) begin
    if (RST || soft_rst_reg) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (dnr_reg && init_cnt_reg == IW'(INIT_CYCLES - 1)) | // R5 R6
        (done_reg & ~clr_done);
    end
  end

  // latched lock-loss flags, set wins over clear
  always_ff @(posedge CLK) begin
    if (RST || soft_rst_reg) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= lane_pair_t'((flag_reg & ~clr_lock) | lock_s); // R13 R18 R19
    end
  end

  // interrupt request
  always_ff @(posedge CLK) begin
    if (RST || soft_rst_reg) begin
      irq_oe_reg <= 1'b0;
    end else begin
      irq_oe_reg <= (|(flag_reg & ~mask_s)) | done_reg; // R9 R20 R23
    end
  end

  // power state
  always_ff @(posedge CLK) begin
    if (RST) begin
      power_low_reg <= 1'b0;
    end else begin
      power_low_reg <= lp_s2 | pd_s2; // R7 R22
    end
  end

  assign INTERRUPT_N_O = 1'b0;
  assign INTERRUPT_N_OE = irq_oe_reg;
  assign MODULE_PRESENT_N = 1'b0; // R8
  assign POWER_LOW = power_low_reg;
  assign TX_RETIMER_ENABLE = ret_s[7:4]; // R14
  assign RX_RETIMER_ENABLE = ret_s[3:0]; // R14

  // ---------------- link domain ----------------

  always_ff @(negedge SCL) begin
    rst_scl_s1 <= link_rst_req_reg;
    rst_scl_reg <= rst_scl_s1;
    sel_n_s1 <= MODULE_SELECT_N;
    sel_n_s2 <= sel_n_s1;
    flags_s1 <= flag_reg;
    flags_scl <= flags_s1;
    dnr_s1 <= dnr_reg;
    dnr_scl <= dnr_s1;
  end

  // data sampled in the high phase
  always_ff @(posedge SCL) begin
    if (rst_scl_reg) begin
      sda_hi_reg <= 1'b1;
    end else begin
      sda_hi_reg <= SDA_I;
    end
  end

  assign start_c = sda_hi_reg & ~SDA_I;
  assign stop_c = ~sda_hi_reg & SDA_I;
  assign link_go = ~sel_n_s2 & ~start_c & ~stop_c; // R1 R2 R21
  assign byte_in = {sh_reg[6:0], sda_hi_reg};
  assign byte_done = (cnt_reg == 3'h7);
  assign page_sel = mem_reg[0][OFS_PAGE_SEL[6:0]];
  assign row_ok = !offset_reg[7] || (page_sel < 8'(PAGES)); // R11
  assign row_idx = offset_reg[7] ? PW'(page_sel + 8'h01) : '0;
  assign writable = row_ok && ((!offset_reg[7] && offset_reg >= LOWER_RW_FIRST) || // R15
    (offset_reg[7] && offset_reg >= UPPER_RW_FIRST));
  assign load_rd = link_go && ((state_reg == ST_ACK_ADDR && rw_reg) ||
    (state_reg == ST_RACK && !sda_hi_reg));
  assign wr_now = link_go && state_reg == ST_WDATA && byte_done && writable;

  always_comb begin
    rd_value = 8'h00;
    if (offset_reg == OFS_STATUS) begin
      rd_value[DNR_BIT] = dnr_scl; // R5
    end else if (offset_reg == OFS_LOCK_FLAGS) begin
      rd_value = flags_scl; // R13
    end else if (row_ok) begin
      rd_value = mem_reg[row_idx][offset_reg[6:0]];
    end
  end

  // bus engine
  always_ff @(negedge SCL) begin
    if (rst_scl_reg || sel_n_s2 || stop_c) begin
      state_reg <= ST_IDLE; // R2 R21
      sda_oe_reg <= 1'b0;
      cnt_reg <= 3'h0;
    end else if (start_c) begin
      state_reg <= ST_ADDR;
      sda_oe_reg <= 1'b0;
      cnt_reg <= 3'h0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        ST_ADDR, ST_OFFS, ST_WDATA: begin
          sh_reg <= byte_in;
          cnt_reg <= cnt_reg + 3'h1;
          if (byte_done) begin
            sda_oe_reg <= 1'b1;
            if (state_reg == ST_ADDR) begin
              rw_reg <= byte_in[0];
              if (byte_in[7:1] == DEV_ADDR) begin
                state_reg <= ST_ACK_ADDR; // R12
              end else begin
                state_reg <= ST_IDLE;
                sda_oe_reg <= 1'b0;
              end
            end else if (state_reg == ST_OFFS) begin
              offset_reg <= byte_in;
              state_reg <= ST_ACK_OFFS;
            end else begin
              offset_reg <= offset_reg + 8'h01;
              state_reg <= ST_ACK_W;
            end
          end
        end
        ST_ACK_ADDR, ST_RACK: begin
          cnt_reg <= 3'h0;
          if (load_rd) begin
            tx_reg <= rd_value;
            sda_oe_reg <= ~rd_value[7];
            offset_reg <= offset_reg + 8'h01;
            state_reg <= ST_RDATA;
          end else begin
            sda_oe_reg <= 1'b0;
            state_reg <= (state_reg == ST_ACK_ADDR) ? ST_OFFS : ST_IDLE;
          end
        end
        ST_ACK_OFFS, ST_ACK_W: begin
          sda_oe_reg <= 1'b0;
          cnt_reg <= 3'h0;
          state_reg <= ST_WDATA;
        end
        ST_RDATA: begin
          if (byte_done) begin
            sda_oe_reg <= 1'b0;
            state_reg <= ST_RACK;
          end else begin
            sda_oe_reg <= ~tx_reg[6];
            tx_reg <= {tx_reg[6:0], 1'b0};
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // management memory
  always_ff @(negedge SCL) begin
    if (rst_scl_reg) begin
      for (int r = 0; r <= PAGES; r++) begin
        for (int c = 0; c < 128; c++) begin
          mem_reg[r][c] <= MEM_RST; // R3
        end
      end
    end else if (wr_now) begin
      mem_reg[row_idx][offset_reg[6:0]] <= byte_in; // R14 R15
    end
  end

  // clear-on-read hand-off toward the clk domain
  always_ff @(negedge SCL) begin
    if (rst_scl_reg) begin
      clr_tog_reg <= 1'b0;
      clr_snap_reg <= '0;
    end else if (load_rd && (offset_reg == OFS_STATUS || offset_reg == OFS_LOCK_FLAGS)) begin
      clr_tog_reg <= ~clr_tog_reg; // R19
      clr_snap_reg <= '{is_status: (offset_reg == OFS_STATUS), bits: rd_value};
    end
  end

  assign SDA_O = 1'b0;
  assign SDA_OE = sda_oe_reg;

  // ---------------- checks ----------------

  property p_unmasked_irq;
    @(posedge CLK) disable iff (RST || soft_rst_reg)
      (|(flag_reg & ~mask_s)) |=> irq_oe_reg;
  endproperty
  a_unmasked_irq: assert property (p_unmasked_irq) else $error("irq not raised"); // R23

  property p_irq_release;
    @(posedge CLK) disable iff (RST)
      (!(|(flag_reg & ~mask_s)) && !done_reg) |=> !irq_oe_reg;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("irq not released"); // R19

  property p_done_irq;
    @(posedge CLK) disable iff (RST || soft_rst_reg)
      $fell(dnr_reg) |-> done_reg ##1 irq_oe_reg;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("no completion irq"); // R5

  property p_init_time;
    @(posedge CLK) disable iff (RST || soft_rst_reg)
      (dnr_reg && init_cnt_reg == IW'(INIT_CYCLES - 1)) |=> !dnr_reg;
  endproperty
  a_init_time: assert property (p_init_time) else $error("not ready late"); // R16

  property p_flag_set;
    @(posedge CLK) disable iff (RST || soft_rst_reg)
      (lock_s != 8'h00) |=> ((flag_reg & $past(lock_s)) == $past(lock_s));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not latched"); // R13

  property p_flag_clear;
    @(posedge CLK) disable iff (RST || soft_rst_reg)
      (clr_evt && !clr_snap_reg.is_status && lock_s == 8'h00)
        |=> ((flag_reg & $past(clr_snap_reg.bits)) == 8'h00);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // R19

  property p_soft_reset;
    @(posedge CLK) disable iff (RST)
      $rose(soft_rst_reg) |-> ##1 (dnr_reg && flag_reg == 8'h00 && !irq_oe_reg);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("reset incomplete"); // R3

  property p_low_power;
    @(posedge CLK) disable iff (RST)
      lp_s2 |=> POWER_LOW;
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power missed"); // R7

  property p_pdown;
    @(posedge CLK) disable iff (RST)
      (pd_s2 ##1 pd_s2) |-> POWER_LOW;
  endproperty
  a_pdown: assert property (p_pdown) else $error("override ignored"); // R22

  property p_present;
    @(posedge CLK) disable iff (RST)
      !MODULE_PRESENT_N;
  endproperty
  a_present: assert property (p_present) else $error("presence not low"); // R8

  property p_deselect_quiet;
    @(negedge SCL) disable iff (rst_scl_reg)
      sel_n_s2 |=> (!sda_oe_reg && state_reg == ST_IDLE);
  endproperty
  a_deselect_quiet: assert property (p_deselect_quiet) else $error("bus driven"); // R2

  property p_addr_ack;
    @(negedge SCL) disable iff (rst_scl_reg)
      (state_reg == ST_ADDR && byte_done && link_go && byte_in[7:1] == DEV_ADDR)
        |=> (sda_oe_reg && state_reg == ST_ACK_ADDR);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acked"); // R12

  property p_addr_nack;
    @(negedge SCL) disable iff (rst_scl_reg)
      (state_reg == ST_ADDR && byte_done && link_go && byte_in[7:1] != DEV_ADDR)
        |=> (!sda_oe_reg && state_reg == ST_IDLE);
  endproperty
  a_addr_nack: assert property (p_addr_nack) else $error("foreign address acked"); // R1

endmodule // module_mgmt_control_logic

`default_nettype wire

// >>> host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model import mgmt_pkg::*; (
  // bus pins
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  initial begin
    scl = 1'b0;
    sda_drv = 1'b1;
  end
  // data moves only in the low phase; the bus clock idles low between frames
  task automatic bit_io(input logic b, output logic r);
    #8 sda_drv = b;
    #8 scl = 1'b1;
    #4 r = sda;
    #12 scl = 1'b0;
  endtask
  task automatic idle(input int n);
    logic r;
    repeat (n) bit_io(1'b1, r);
  endtask
  task automatic start_c;
    #8 sda_drv = 1'b1;
    #8 scl = 1'b1;
    #8 sda_drv = 1'b0;
    #8 scl = 1'b0;
  endtask
  // the stop is only seen at a later falling edge, so clock a little past it
  task automatic stop_c;
    #8 sda_drv = 1'b0;
    #8 scl = 1'b1;
    #8 sda_drv = 1'b1;
    #8 scl = 1'b0;
    idle(2);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
  task automatic wr(input logic [7:0] dev, input logic [7:0] ofs, input logic [7:0] d,
                    output logic ack);
    logic a0, a1, a2;
    start_c();
    send(dev, a0);
    send(ofs, a1);
    send(d, a2);
    stop_c();
    ack = a0 & a1 & a2;
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d, output logic ack);
    logic a0, a1, a2;
    start_c();
    send({DEV_ADDR, 1'b0}, a0);
    send(ofs, a1);
    start_c();
    send({DEV_ADDR, 1'b1}, a2);
    recv(1'b1, d);
    stop_c();
    ack = a0 & a1 & a2;
  endtask
endmodule // host_bus_model
`default_nettype wire

// >>> module_mgmt_control_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module module_mgmt_control_logic_tb import mgmt_pkg::*; ;
  localparam int INIT = 200;
  localparam logic [7:0] WA = {DEV_ADDR, 1'b0};
  logic clk, rst, scl, sda_drv, sda, sel_n, rst_n, lp_req;
  logic [3:0] tx_ll, rx_ll, tx_en, rx_en;
  logic sda_o, sda_oe, prs_n, irq_o, irq_oe, pwr_low, irq_n, ack;
  logic [7:0] d;
  int miscompares, total_checks;
  assign sda = (sda_oe ? sda_o : 1'b1) & sda_drv;
  assign irq_n = irq_oe ? irq_o : 1'b1;
  module_mgmt_control_logic #(.INIT_CYCLES(INIT)) uut (
    .CLK(clk), .RST(rst), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .MODULE_SELECT_N(sel_n), .MODULE_RESET_N(rst_n), .LOW_POWER_REQUEST(lp_req),
    .MODULE_PRESENT_N(prs_n), .INTERRUPT_N_O(irq_o), .INTERRUPT_N_OE(irq_oe),
    .TX_LOCK_LOST(tx_ll), .RX_LOCK_LOST(rx_ll), .TX_RETIMER_ENABLE(tx_en),
    .RX_RETIMER_ENABLE(rx_en), .POWER_LOW(pwr_low));
  host_bus_model host (.scl(scl), .sda_drv(sda_drv), .sda(sda));
  always #12.5 clk = ~clk;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_irq(input logic v, input int n);
    int k;
    k = 0;
    while (irq_n !== v && k < n) begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic t_power_up;
    check("present", 8'(prs_n), 8'h00);
    check("irq early", 8'(irq_n), 8'h01);
    host.rd(OFS_STATUS, d, ack);
    check("not ready", 8'(d[DNR_BIT]), 8'h01);
    wait_irq(1'b0, INIT + 100);
    check("done irq", 8'(irq_n), 8'h00);
    host.rd(OFS_STATUS, d, ack);
    check("ready", 8'(d[DNR_BIT]), 8'h00);
    check("status ack", 8'(ack), 8'h01);
    wait_irq(1'b1, 20);
    check("irq off", 8'(irq_n), 8'h01);
    $display("t_power_up done");
  endtask
  task automatic t_regs;
    host.wr(WA, OFS_RETIMER_EN, 8'hA5, ack);
    check("wr ack", 8'(ack), 8'h01);
    host.rd(OFS_RETIMER_EN, d, ack);
    check("retimer byte", d, 8'hA5);
    cyc(6);
    check("retimer pins", {tx_en, rx_en}, 8'hA5);
    host.wr(WA, 8'hF0, 8'h3C, ack);
    host.rd(8'hF0, d, ack);
    check("upper rw", d, 8'h3C);
    host.wr(WA, 8'h80, 8'h77, ack);
    host.rd(8'h80, d, ack);
    check("upper ro", d, MEM_RST);
    $display("t_regs done");
  endtask
  task automatic pulse(input logic [3:0] t, input logic [3:0] r);
    tx_ll = t;
    rx_ll = r;
    cyc(4);
    tx_ll = 4'h0;
    rx_ll = 4'h0;
  endtask
  task automatic t_flags;
    pulse(4'h8, 4'h1);
    wait_irq(1'b0, 10);
    check("flag irq", 8'(irq_n), 8'h00);
    host.rd(OFS_LOCK_FLAGS, d, ack);
    check("flags", d, 8'h81);
    wait_irq(1'b1, 20);
    check("irq clear", 8'(irq_n), 8'h01);
    host.rd(OFS_LOCK_FLAGS, d, ack);
    check("flags clear", d, 8'h00);
    $display("t_flags done");
  endtask
  task automatic t_mask;
    host.wr(WA, OFS_LOCK_MASK, 8'hFF, ack);
    pulse(4'h0, 4'h2);
    cyc(10);
    check("masked", 8'(irq_n), 8'h01);
    host.wr(WA, OFS_LOCK_MASK, 8'h00, ack);
    wait_irq(1'b0, 20);
    check("unmasked", 8'(irq_n), 8'h00);
    host.rd(OFS_LOCK_FLAGS, d, ack);
    check("rx2 flag", d, 8'h02);
    wait_irq(1'b1, 20);
    check("irq gone", 8'(irq_n), 8'h01);
    $display("t_mask done");
  endtask
  task automatic t_select;
    sel_n = 1'b1;
    host.idle(3);
    host.wr(WA, OFS_RETIMER_EN, 8'h11, ack);
    check("deselect ack", 8'(ack), 8'h00);
    @(negedge clk);
    sel_n = 1'b0;
    host.idle(3);
    host.wr(8'hA2, OFS_RETIMER_EN, 8'h11, ack);
    check("bad addr ack", 8'(ack), 8'h00);
    host.rd(OFS_RETIMER_EN, d, ack);
    check("select ack", 8'(ack), 8'h01);
    check("unchanged", d, 8'hA5);
    $display("t_select done");
  endtask
  task automatic t_power;
    lp_req = 1'b1;
    cyc(6);
    check("lp on", 8'(pwr_low), 8'h01);
    lp_req = 1'b0;
    cyc(6);
    check("lp off", 8'(pwr_low), 8'h00);
    host.wr(WA, OFS_POWER_CTRL, 8'h01, ack);
    cyc(6);
    check("pd on", 8'(pwr_low), 8'h01);
    host.wr(WA, OFS_POWER_CTRL, 8'h00, ack);
    cyc(6);
    check("pd off", 8'(pwr_low), 8'h00);
    $display("t_power done");
  endtask
  task automatic t_pin_reset;
    rst_n = 1'b0;
    // the bus clock must run while reset is held so the memory clears
    fork
      cyc(RESET_MIN_CYC + 10);
      host.idle(80);
    join
    rst_n = 1'b1;
    host.idle(4);
    cyc(4);
    check("pins default", {tx_en, rx_en}, 8'h00);
    wait_irq(1'b0, INIT + 100);
    check("reset done", 8'(irq_n), 8'h00);
    host.rd(OFS_RETIMER_EN, d, ack);
    check("byte default", d, 8'h00);
    $display("t_pin_reset done");
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    sel_n = 1'b0;
    rst_n = 1'b1;
    lp_req = 1'b0;
    tx_ll = 4'h0;
    rx_ll = 4'h0;
    miscompares = 0;
    total_checks = 0;
    fork
      cyc(5);
      host.idle(6);
    join
    @(negedge clk);
    rst = 1'b0;
    host.idle(4);
    t_power_up();
    t_regs();
    t_flags();
    t_mask();
    t_select();
    t_power();
    t_pin_reset();
    print_verdict();
  end
  initial begin
    #400_000;
    miscompares++;
    print_verdict();
  end
endmodule // module_mgmt_control_logic_tb
`default_nettype wire
